// ### hw/image_sensor_pixel_output.sv
// Pixel timing generator, clock-crossing FIFO and parallel pixel output stage.
`timescale 1ns/1ps
`default_nettype none
`include "pix_params.svh"

module pixel_async_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             wr_clk_in,
  input  wire logic             wr_reset_in,
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  input  wire logic             rd_clk_in,
  input  wire logic             rd_reset_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic [WIDTH-1:0]      rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_bin, rd_bin, wr_gray, rd_gray;
  logic [AW:0]      rd_gray_meta, rd_gray_sync, wr_gray_meta, wr_gray_sync;
  logic [AW:0]      next_wr_bin, next_rd_bin;
  logic             push, pop;

  assign push = wr_valid_in && wr_ready_out;
  assign pop  = rd_valid_out && rd_ready_in;
  assign next_wr_bin = wr_bin + (AW+1)'(push);
  assign next_rd_bin = rd_bin + (AW+1)'(pop);
  // Full compares gray pointers, so a pointer caught mid-change only delays the flag.
  assign wr_ready_out = (wr_gray != {~rd_gray_sync[AW:AW-1], rd_gray_sync[AW-2:0]});
  assign rd_valid_out = (rd_gray != wr_gray_sync);
  assign rd_data_out  = mem[rd_bin[AW-1:0]];

  always_ff @(posedge wr_clk_in) begin
    if (push) begin
      mem[wr_bin[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge wr_clk_in) begin
    if (wr_reset_in) begin
      wr_bin       <= '0;
      wr_gray      <= '0;
      rd_gray_meta <= '0;
      rd_gray_sync <= '0;
    end else begin
      wr_bin       <= next_wr_bin;
      wr_gray      <= next_wr_bin ^ (next_wr_bin >> 1);
      rd_gray_meta <= rd_gray;
      rd_gray_sync <= rd_gray_meta;
    end
  end

  always_ff @(posedge rd_clk_in) begin
    if (rd_reset_in) begin
      rd_bin       <= '0;
      rd_gray      <= '0;
      wr_gray_meta <= '0;
      wr_gray_sync <= '0;
    end else begin
      rd_bin       <= next_rd_bin;
      rd_gray      <= next_rd_bin ^ (next_rd_bin >> 1);
      wr_gray_meta <= wr_gray;
      wr_gray_sync <= wr_gray_meta;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge wr_clk_in) disable iff (wr_reset_in)
    !wr_ready_out |=> (wr_bin == $past(wr_bin)))
    else $error("FIFO write pointer moved while full.");
endmodule

module image_sensor_pixel_output (
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 link_clk_in,
  input  wire pix_pkg::sensor_cfg_t cfg_in,
  output logic [`PIX_W-1:0]         pixel_data_out,
  output logic                      pixel_output_clock_out,
  output logic                      line_valid_out,
  output logic                      frame_valid_out,
  output logic                      strobe_out
);
  import pix_pkg::*;

  sensor_cfg_t       cfg_meta, cfg_sync, cfg;
  logic              phase;
  logic [`CNT_W-1:0] col, row;
  logic              in_rows, in_cols, wr_ready, push;
  pixel_word_t       gen_word, rd_word;
  logic              rd_valid, rd_ready;
  logic              link_reset_meta, link_reset;
  logic [`CNT_W-1:0] strobe_row;

  // Configuration pins come from outside this clock and pass two flip-flops first.
  // The pair samples through reset, so a setting held in reset governs the first pixel.
  always_ff @(posedge clk_in) begin
    cfg_meta <= cfg_in;
    cfg_sync <= cfg_meta;
  end

  always_comb begin
    cfg = cfg_sync;
    if (!cfg_sync.program_enable) begin
      cfg.col_start = `DEF_COL_START;
      cfg.row_start = `DEF_ROW_START;
      cfg.width     = `ACTIVE_COLS;
      cfg.height    = `ACTIVE_ROWS;
      cfg.exposure  = `DEF_EXPOSURE;
      cfg.gain      = `DEF_GAIN;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  // A full FIFO stalls the raster rather than dropping a pixel.
  assign push = phase && wr_ready;

  // frame period of thirty per second
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      col <= '0;
      row <= '0;
    end else if (push) begin
      if (col == `H_LAST) begin
        col <= '0;
        row <= (row == `V_LAST) ? '0 : row + 10'd1;
      end else begin
        col <= col + 10'd1;
      end
    end
  end

  assign in_rows = (row >= cfg.row_start) && (row < cfg.row_start + cfg.height)
                   && (row < `ARRAY_ROWS);
  assign in_cols = (col >= cfg.col_start) && (col < cfg.col_start + cfg.width)
                   && (col < `ARRAY_COLS);

  // Bayer colour in the top bits
  always_comb begin
    gen_word.sample      = {row[0], col[0], 8'(col + {2'b00, cfg.gain})};
    gen_word.line_valid  = in_rows && in_cols;
    gen_word.frame_valid = in_rows;
  end

  assign strobe_row = `V_LAST - cfg.exposure;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      strobe_out <= 1'b0;
    end else begin
      strobe_out <= (row > strobe_row) || (row == `V_LAST);
    end
  end

  pixel_async_fifo #(
    .WIDTH ($bits(pixel_word_t)),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .wr_clk_in    (clk_in),
    .wr_reset_in  (reset_in),
    .wr_valid_in  (phase),
    .wr_data_in   (gen_word),
    .wr_ready_out (wr_ready),
    .rd_clk_in    (link_clk_in),
    .rd_reset_in  (link_reset),
    .rd_valid_out (rd_valid),
    .rd_ready_in  (rd_ready),
    .rd_data_out  (rd_word)
  );

  always_ff @(posedge link_clk_in) begin
    link_reset_meta <= reset_in;
    link_reset      <= link_reset_meta;
  end

  // pixel clock made on the link side
  always_ff @(posedge link_clk_in) begin
    if (link_reset) begin
      pixel_output_clock_out <= 1'b0;
    end else begin
      pixel_output_clock_out <= ~pixel_output_clock_out;
    end
  end

  // Data moves on the falling pixel clock so the host samples a settled bus on the rise.
  assign rd_ready = pixel_output_clock_out;

  always_ff @(posedge link_clk_in) begin
    if (link_reset) begin
      pixel_data_out  <= '0;
      line_valid_out  <= 1'b0;
      frame_valid_out <= 1'b0;
    end else if (rd_ready) begin
      if (rd_valid) begin
        pixel_data_out  <= rd_word.sample;
        line_valid_out  <= rd_word.line_valid;
        frame_valid_out <= rd_word.frame_valid;
      end else begin
        // An underrun shows as a blank pixel; the frame qualifier is held.
        line_valid_out <= 1'b0;
      end
    end
  end

  sequence s_push_step;
    push ##1 !push;
  endsequence

  a_push_pacing: assert property (@(posedge clk_in) disable iff (reset_in)
    push |-> s_push_step)
    else $error("Two pixels generated in consecutive clocks.");

  a_array_bounds: assert property (@(posedge clk_in) disable iff (reset_in)
    gen_word.line_valid |-> (col < `ARRAY_COLS) && (row < `ARRAY_ROWS))
    else $error("Valid pixel outside the sensor array.");

  a_bayer_order: assert property (@(posedge clk_in) disable iff (reset_in)
    push && gen_word.line_valid |-> gen_word.sample[9:8] == {row[0], col[0]})
    else $error("Bayer colour code does not match row and column.");

  a_default_size: assert property (@(posedge clk_in) disable iff (reset_in)
    !cfg_sync.program_enable |-> cfg.width == `ACTIVE_COLS && cfg.height == `ACTIVE_ROWS)
    else $error("Default frame size is not VGA.");

  // frame period of thirty per second
  a_row_wrap: assert property (@(posedge clk_in) disable iff (reset_in)
    push && col == `H_LAST && row == `V_LAST |=> row == '0 && col == '0)
    else $error("Frame did not wrap after the last line.");

  a_col_wrap: assert property (@(posedge clk_in) disable iff (reset_in)
    push && col == `H_LAST |=> col == '0 && row != $past(row))
    else $error("Line did not wrap after the last column.");

  a_strobe_window: assert property (@(posedge clk_in) disable iff (reset_in)
    $stable(row) && $stable(cfg.exposure) && (row > strobe_row) |=> strobe_out)
    else $error("Strobe low during the exposure rows.");

  sequence s_clk_half;
    pixel_output_clock_out ##1 !pixel_output_clock_out ##1 pixel_output_clock_out;
  endsequence

  // pixel clock made on the link side
  a_pixel_output_clock_toggle: assert property (@(posedge link_clk_in) disable iff (link_reset)
    pixel_output_clock_out |-> s_clk_half)
    else $error("Pixel output clock did not toggle every link clock.");

  a_data_on_fall: assert property (@(posedge link_clk_in) disable iff (link_reset)
    $changed(pixel_data_out) |-> !pixel_output_clock_out)
    else $error("Pixel data changed away from the falling pixel clock.");

  a_line_in_frame: assert property (@(posedge link_clk_in) disable iff (link_reset)
    line_valid_out |-> frame_valid_out)
    else $error("Line qualifier high outside a frame.");
endmodule
`default_nettype wire

// ### shared/pix_params.svh
// Constants for the image sensor pixel output block.
// Function
// - Each pixel becomes one ten-bit sample value.
// - Samples leave on a ten-bit bus with pixel clock, line and frame qualifiers.
// - Unprogrammed, the device delivers VGA frames at thirty frames per second.
// - The scanned array spans 649 columns by 489 rows.
// - A strobe output follows the exposure interval for an external light.
// - Frame size, exposure and gain are set by programming inputs.
// - One pixel leaves every two clock cycles, half the clock rate.
// - Rows alternate green/red and blue/green Bayer pixels.
`ifndef PIX_PARAMS_SVH
`define PIX_PARAMS_SVH
`define PIX_W           10
`define CNT_W           10
`define ARRAY_COLS      10'd649
`define ARRAY_ROWS      10'd489
`define ACTIVE_COLS     10'd640
`define ACTIVE_ROWS     10'd480
`define DEF_COL_START   10'd4
`define DEF_ROW_START   10'd4
`define DEF_EXPOSURE    10'd16
`define DEF_GAIN        8'h00
`define CLK_HZ          25000000
`define FRAME_RATE      30
`define CLKS_PER_PIXEL  2
`define H_TOTAL         800
`define V_TOTAL         (`CLK_HZ / `CLKS_PER_PIXEL / `FRAME_RATE / `H_TOTAL)
`define H_LAST          10'(`H_TOTAL - 1)
`define V_LAST          10'(`V_TOTAL - 1)
`define FIFO_DEPTH      8
`endif

// ### shared/pix_pkg.sv
// Types shared by the image sensor pixel output block.
`include "pix_params.svh"
package pix_pkg;
  typedef struct packed {
    logic [`PIX_W-1:0] sample;
    logic              line_valid;
    logic              frame_valid;
  } pixel_word_t;

  typedef struct packed {
    logic              program_enable;
    logic [`CNT_W-1:0] col_start;
    logic [`CNT_W-1:0] row_start;
    logic [`CNT_W-1:0] width;
    logic [`CNT_W-1:0] height;
    logic [`CNT_W-1:0] exposure;
    logic [7:0]        gain;
  } sensor_cfg_t;
endpackage

// ### tb/host_capture.sv
// Host-side capture model for the parallel pixel bus.
`timescale 1ns/1ps
`default_nettype none
`include "pix_params.svh"
module host_capture (
  input  wire logic              pclk_in,
  input  wire logic [`PIX_W-1:0] data_in,
  input  wire logic              line_valid_in,
  input  wire logic              frame_valid_in
);
  logic [`PIX_W-1:0] got[$];
  realtime           stamp[$];
  // qualified capture only.
  // Blanking words are dropped here, so the bench sees only real pixels.
  always @(posedge pclk_in) begin
    if (line_valid_in && frame_valid_in) begin
      got.push_back(data_in);
      stamp.push_back($realtime);
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the pixel output block.
`timescale 1ns/1ps
`default_nettype none
`include "pix_params.svh"
module tb_top;
  import pix_pkg::*;
  logic              clk_in = 1'b0;
  logic              link_clk_in = 1'b0;
  logic              reset_in = 1'b1;
  sensor_cfg_t       cfg_in = '0;
  logic [`PIX_W-1:0] pixel_data_out;
  logic              pclk;
  logic              lv;
  logic              fv;
  logic              strobe_out;
  int                n_mismatch = 0;
  int                comparisons = 0;

  always #20 clk_in = ~clk_in;
  // The odd start keeps the link clock out of phase with the master clock.
  initial begin
    #1.7;
    forever #3 link_clk_in = ~link_clk_in;
  end

  image_sensor_pixel_output dut_u (
    .clk_in                 (clk_in),
    .reset_in               (reset_in),
    .link_clk_in            (link_clk_in),
    .cfg_in                 (cfg_in),
    .pixel_data_out         (pixel_data_out),
    .pixel_output_clock_out (pclk),
    .line_valid_out         (lv),
    .frame_valid_out        (fv),
    .strobe_out             (strobe_out)
  );

  host_capture host_u (
    .pclk_in        (pclk),
    .data_in        (pixel_data_out),
    .line_valid_in  (lv),
    .frame_valid_in (fv)
  );

  task automatic complete_run();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("FAIL at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic do_reset(input sensor_cfg_t cfg);
    reset_in = 1'b1;
    cfg_in = cfg;
    wait_clk(8);
    check({pixel_data_out, pclk, lv, fv, strobe_out}, 16'h0, "reset outputs");
    host_u.got.delete();
    host_u.stamp.delete();
    reset_in = 1'b0;
  endtask

  // A bounded wait: running out counts as a mismatch and ends the run.
  task automatic wait_words(input int n, input int limit);
    int i;
    for (i = 0; i < limit && host_u.got.size() < n; i++) begin
      wait_clk(1);
    end
    if (host_u.got.size() < n) begin
      n_mismatch++;
      $display("FAIL at %0t: pixel wait timed out", $time);
      complete_run();
    end
  endtask

  // Full-width window, two rows, gain and long exposure programmed.
  task automatic test_full_rows();
    sensor_cfg_t cfg;
    logic [9:0]  want;
    realtime     dt;
    cfg = '{1'b1, 10'h000, 10'h000, 10'h3ff, 10'h002, 10'h207, 8'h05};
    do_reset(cfg);
    wait_clk(400);
    check(strobe_out, 1'b0, "strobe in row 0");
    wait_words(1298, 4000);
    check(strobe_out, 1'b1, "strobe in row 1");
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 649; c++) begin
        want = {r[0], c[0], 8'(c + 5)};
        check(host_u.got[r * 649 + c], want, "pixel word");
      end
    end
    check(host_u.got[649][9:8], 2'h2, "second row colour");
    dt = host_u.stamp[648] - host_u.stamp[0];
    check(16'(dt > 51740.0 && dt < 51940.0), 16'h1, "pixel spacing");
    wait_clk(3200);
    check(16'(host_u.got.size()), 16'd1298, "programmed height");
  endtask

  // Unprogrammed start: window opens at row 4, column 4, 640 wide.
  task automatic test_defaults();
    do_reset('0);
    wait_clk(6000);
    check({fv, strobe_out}, 2'h0, "blank top rows");
    wait_words(640, 3000);
    check(host_u.got[0], 10'h004, "first default pixel");
    check(host_u.got[639], 10'h183, "last default pixel");
    wait_clk(100);
    check(16'(host_u.got.size()), 16'd640, "default width");
  endtask

  initial begin
    test_full_rows();
    test_defaults();
    complete_run();
  end
endmodule
`default_nettype wire
